// [design/ppc_pkg.sv]
// Package with register map, reset values and carrier types of the port configuration block.
package ppc_pkg;
	localparam logic [7:0] ADDR_P2_PIN_DATA = 8'ha0;
	localparam logic [7:0] ADDR_P1_DRIVE_SEL = 8'ha5;
	localparam logic [7:0] ADDR_P2_DRIVE_SEL = 8'ha6;
	localparam logic [7:0] ADDR_P1_BYPASS = 8'hd5;
	localparam logic [7:0] ADDR_P1_ANALOG_SEL = 8'hf2;
	localparam logic [7:0] RST_P1_ANALOG_SEL = 8'hff;
	localparam logic [7:0] RST_P1_DRIVE_SEL = 8'h00;
	localparam logic [7:0] RST_P1_BYPASS = 8'h00;
	localparam logic RST_P2_LATCH = 1'b1;
	localparam logic RST_P2_DRIVE = 1'b0;
	localparam logic [6:0] P1_BYPASS_MASK = 7'h7f;
	localparam int P2_DATA_BIT = 0;
	localparam int P1_WIDTH = 8;

	// One special-register access from the core.
	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_idx;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ppc_sfr_req_s;

	// Drive controls of one pin.
	typedef struct packed {
		logic out_val;
		logic out_en;
		logic pullup_en;
		logic rx_en;
	} ppc_pin_ctl_s;
endpackage : ppc_pkg

// [design/ppc_top.sv]
// Port 1 and Port 2 pin configuration and Port 2 data logic behind the special-register bus.
module ppc_top #(
	parameter int P1_PINS = ppc_pkg::P1_WIDTH
) (
	// Clock and reset.
	input wire logic REF_CLK,
	input wire logic RSTN,
	// Special-register bus from the core.
	input wire ppc_pkg::ppc_sfr_req_s SFR_REQ,
	output logic [7:0] SFR_RDATA,
	// Port 1 output levels from the crossbar or data latch.
	input wire logic [P1_PINS-1:0] P1_OUT_LEVEL,
	input wire logic [P1_PINS-1:0] P1_PIN_IN,
	input wire logic [P1_PINS-1:0] P1_TWO_WIRE,
	// Port 1 pad controls.
	output logic [P1_PINS-1:0] P1_PAD_OUT,
	output logic [P1_PINS-1:0] P1_PAD_OE,
	output logic [P1_PINS-1:0] P1_PAD_PULLUP_EN,
	output logic [P1_PINS-1:0] P1_PAD_RX_EN,
	output logic [P1_PINS-1:0] P1_PIN_LEVEL,
	output logic [6:0] P1_CROSSBAR_SKIP,
	// Port 2 pin.
	input wire logic P2_PIN_IN,
	output logic P2_PAD_OUT,
	output logic P2_PAD_OE
);
	// Configuration state written over the bus.
	logic [7:0] p1_analog_sel_q, p1_analog_sel_d;
	logic [7:0] p1_drive_sel_q, p1_drive_sel_d;
	logic [6:0] p1_bypass_q, p1_bypass_d;
	logic p2_latch_q, p2_latch_d;
	logic p2_drive_q, p2_drive_d;

	// Read path: registered read data and the Port 2 read image.
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] p2_read_image;

	// Pad controls; every pad output leaves a flip-flop.
	logic [P1_PINS-1:0] p1_out_q, p1_out_d;
	logic [P1_PINS-1:0] p1_oe_q, p1_oe_d;
	logic [P1_PINS-1:0] p1_pu_q, p1_pu_d;
	logic [P1_PINS-1:0] p1_rx_q, p1_rx_d;
	logic [P1_PINS-1:0] p1_lvl_q, p1_lvl_d;
	logic p2_out_q, p2_out_d;
	logic p2_oe_q, p2_oe_d;

	// Port 2 reads the pin, never the latch, so a load fighting the driver is visible.
	// pin level readback
	assign p2_read_image = {7'h00, P2_PIN_IN};

	// Register writes, including single-bit writes on the data register.
	always_comb begin
		p1_analog_sel_d = p1_analog_sel_q;
		p1_drive_sel_d = p1_drive_sel_q;
		p1_bypass_d = p1_bypass_q;
		p2_latch_d = p2_latch_q;
		p2_drive_d = p2_drive_q;
		if (SFR_REQ.wr) begin
			case (SFR_REQ.addr)
				ppc_pkg::ADDR_P1_ANALOG_SEL: begin
					p1_analog_sel_d = SFR_REQ.wdata;
				end
				ppc_pkg::ADDR_P1_DRIVE_SEL: begin
					p1_drive_sel_d = SFR_REQ.wdata;
				end
				ppc_pkg::ADDR_P1_BYPASS: begin
					p1_bypass_d = SFR_REQ.wdata[6:0] & ppc_pkg::P1_BYPASS_MASK;
				end
				ppc_pkg::ADDR_P2_PIN_DATA: begin
					if (!SFR_REQ.bit_op) begin
						p2_latch_d = SFR_REQ.wdata[ppc_pkg::P2_DATA_BIT];
					end else if (SFR_REQ.bit_idx == 3'h0) begin
						p2_latch_d = SFR_REQ.wdata[ppc_pkg::P2_DATA_BIT];
					end
				end
				ppc_pkg::ADDR_P2_DRIVE_SEL: begin
					p2_drive_d = SFR_REQ.wdata[0];
				end
				default: begin
				end
			endcase
		end
	end

	// Configuration registers; only the bus writes above change them.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			p1_analog_sel_q <= ppc_pkg::RST_P1_ANALOG_SEL;
			p1_drive_sel_q <= ppc_pkg::RST_P1_DRIVE_SEL;
			p1_bypass_q <= ppc_pkg::RST_P1_BYPASS[6:0];
			p2_latch_q <= ppc_pkg::RST_P2_LATCH;
			p2_drive_q <= ppc_pkg::RST_P2_DRIVE;
		end else begin
			p1_analog_sel_q <= p1_analog_sel_d;
			p1_drive_sel_q <= p1_drive_sel_d;
			p1_bypass_q <= p1_bypass_d;
			p2_latch_q <= p2_latch_d;
			p2_drive_q <= p2_drive_d;
		end
	end

	// Read data is registered; it appears the cycle after the read strobe.
	always_comb begin
		rdata_d = 8'h00;
		if (SFR_REQ.rd) begin
			case (SFR_REQ.addr)
				ppc_pkg::ADDR_P1_ANALOG_SEL: rdata_d = p1_analog_sel_q;
				ppc_pkg::ADDR_P1_DRIVE_SEL: rdata_d = p1_drive_sel_q;
				ppc_pkg::ADDR_P1_BYPASS: rdata_d = {1'b0, p1_bypass_q};
				ppc_pkg::ADDR_P2_PIN_DATA: begin
					if (SFR_REQ.bit_op) begin
						rdata_d = {7'h00, p2_read_image[SFR_REQ.bit_idx]};
					end else begin
						rdata_d = p2_read_image;
					end
				end
				ppc_pkg::ADDR_P2_DRIVE_SEL: rdata_d = {7'h00, p2_drive_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Read data register; it holds zero in any cycle after which no read was strobed.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Port 1 pad control; open-drain drives only low, pull-up supplies the high level.
	// The enable follows the inverse level, so a high level floats up to the pull-up.
	always_comb begin
		for (int i = 0; i < P1_PINS; i++) begin
			p1_rx_d[i] = p1_analog_sel_q[i];
			p1_pu_d[i] = p1_analog_sel_q[i];
			p1_out_d[i] = P1_OUT_LEVEL[i];
			if (!p1_analog_sel_q[i]) begin
				p1_oe_d[i] = 1'b0;
			end else if (p1_drive_sel_q[i] && !P1_TWO_WIRE[i]) begin
				p1_oe_d[i] = 1'b1;
			end else begin
				p1_oe_d[i] = ~P1_OUT_LEVEL[i];
			end
			p1_lvl_d[i] = P1_PIN_IN[i] & p1_analog_sel_q[i];
		end
	end

	// Port 1 pad registers; pads stay undriven with pull-ups off while reset holds.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			p1_out_q <= '0;
			p1_oe_q <= '0;
			p1_pu_q <= '0;
			p1_rx_q <= '0;
			p1_lvl_q <= '0;
		end else begin
			p1_out_q <= p1_out_d;
			p1_oe_q <= p1_oe_d;
			p1_pu_q <= p1_pu_d;
			p1_rx_q <= p1_rx_d;
			p1_lvl_q <= p1_lvl_d;
		end
	end

	// Port 2 pad control; the pin has no analog mode, so only the drive bit and the latch set the enable.
	always_comb begin
		p2_out_d = p2_latch_q;
		p2_oe_d = p2_drive_q | ~p2_latch_q;
	end

	// Port 2 pad registers.
	always_ff @(posedge REF_CLK) begin
		if (!RSTN) begin
			p2_out_q <= 1'b0;
			p2_oe_q <= 1'b0;
		end else begin
			p2_out_q <= p2_out_d;
			p2_oe_q <= p2_oe_d;
		end
	end

	// Outputs come straight from flip-flops.
	// crossbar skip
	assign P1_CROSSBAR_SKIP = p1_bypass_q;
	assign SFR_RDATA = rdata_q;
	assign P1_PAD_OUT = p1_out_q;
	assign P1_PAD_OE = p1_oe_q;
	assign P1_PAD_PULLUP_EN = p1_pu_q;
	assign P1_PAD_RX_EN = p1_rx_q;
	assign P1_PIN_LEVEL = p1_lvl_q;
	assign P2_PAD_OUT = p2_out_q;
	assign P2_PAD_OE = p2_oe_q;
endmodule : ppc_top

// [verif/ppc_asserts.sv]
// Port-level checks for the port configuration block.
module ppc_asserts #(
	parameter int P1_PINS = 8
) (
	// Clock, reset and register bus.
	input wire logic REF_CLK,
	input wire logic RSTN,
	input wire ppc_pkg::ppc_sfr_req_s SFR_REQ,
	input wire logic [7:0] SFR_RDATA,
	// Pads.
	input wire logic [P1_PINS-1:0] P1_TWO_WIRE,
	input wire logic [P1_PINS-1:0] P1_PAD_OUT,
	input wire logic [P1_PINS-1:0] P1_PAD_OE,
	input wire logic [P1_PINS-1:0] P1_PAD_PULLUP_EN,
	input wire logic [P1_PINS-1:0] P1_PAD_RX_EN,
	input wire logic [P1_PINS-1:0] P1_PIN_LEVEL,
	input wire logic P2_PIN_IN
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	logic rd_a0;
	// Port 2 data reads are the cause behind the readback and bit-test checks.
	assign rd_a0 = SFR_REQ.rd && SFR_REQ.addr == 8'ha0;
	a_pull_rx_same: assert property (P1_PAD_PULLUP_EN == P1_PAD_RX_EN)
		else $error("pull-up and receiver disagree");
	a_analog_no_drive: assert property ((P1_PAD_OE & ~P1_PAD_RX_EN) == '0)
		else $error("analog pin driven");
	a_level_gated: assert property ((P1_PIN_LEVEL & ~P1_PAD_RX_EN) == '0)
		else $error("analog pin level seen");
	a_skip_msb_zero: assert property (SFR_REQ.rd && SFR_REQ.addr == 8'hd5 |=> !SFR_RDATA[7])
		else $error("bypass bit 7 not zero");
	a_p2_upper_zero: assert property (SFR_REQ.rd && (SFR_REQ.addr[7:1] == 7'h50
		|| SFR_REQ.addr == ppc_pkg::ADDR_P2_DRIVE_SEL) |=> SFR_RDATA[7:1] == 7'h00)
		else $error("port 2 upper bits set");
	a_rx_follows_sel: assert property (SFR_REQ.wr &&
		SFR_REQ.addr == ppc_pkg::ADDR_P1_ANALOG_SEL
		|=> ##1 P1_PAD_RX_EN == $past(SFR_REQ.wdata, 2)) else $error("receiver not per pin");
	a_p2_readback: assert property (rd_a0 && !SFR_REQ.bit_op |=> SFR_RDATA[0] == $past(P2_PIN_IN))
		else $error("port 2 read not pin");
	a_p2_bit_test: assert property (rd_a0 && SFR_REQ.bit_op && SFR_REQ.bit_idx != 3'h0
		|=> SFR_RDATA == 8'h00) else $error("bit test of unused bit");
	a_two_wire_od: assert property ((P1_PAD_OE & P1_PAD_OUT & $past(P1_TWO_WIRE)) == '0)
		else $error("two-wire pin driven high");
	// Main scenarios reached.
	cover property (rd_a0 && SFR_REQ.bit_op);
	cover property (SFR_REQ.wr && SFR_REQ.addr == 8'hd5);
	cover property (P1_PAD_OE != '0);
endmodule : ppc_asserts

// [verif/ppc_pins.sv]
// Pad model: drivers, pull-ups and an outside low pull, wire-AND.
module ppc_pins (
	// Pad controls and outside pull.
	input wire logic [8:0] pad_out,
	input wire logic [8:0] pad_oe,
	input wire logic [8:0] pad_pu,
	input wire logic [8:0] ext_low,
	// Pad levels.
	output logic [8:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tgl = 1'b0;
	// A floating pin toggles so no settled value can pass by luck.
	always #5 tgl = ~tgl;
	assign pin_in = (pad_oe & pad_out | ~pad_oe & (pad_pu | {9{tgl}})) & ~ext_low;
endmodule : ppc_pins

// [verif/testbench.sv]
// Self-checking bench for the port configuration block.
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic REF_CLK = 0, RSTN = 0, lat, drv, el, p2_out, p2_oe;
	ppc_pkg::ppc_sfr_req_s req = '0;
	logic [7:0] rd, lvl = 0, tw = 0, out, oe, pu, rx, pl, m_in, m_out, sk, d, e;
	logic [8:0] ext = 0, pin;
	logic [6:0] skip;
	logic [2:0] x;
	logic [7:0] ta[6] = '{8'hf2, 8'ha5, 8'hd5, 8'ha6, 8'ha0, 8'h80};
	logic [7:0] te[6] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
	int fail_count = 0, cmp_count = 0, seed = 32'ha0f7;
	always #2.5 REF_CLK = ~REF_CLK;
	ppc_top i_ppc_top (.REF_CLK, .RSTN, .SFR_REQ(req), .SFR_RDATA(rd), .P1_OUT_LEVEL(lvl),
		.P1_PIN_IN(pin[7:0]), .P1_TWO_WIRE(tw), .P1_PAD_OUT(out), .P1_PAD_OE(oe),
		.P1_PAD_PULLUP_EN(pu), .P1_PAD_RX_EN(rx), .P1_PIN_LEVEL(pl),
		.P1_CROSSBAR_SKIP(skip), .P2_PIN_IN(pin[8]), .P2_PAD_OUT(p2_out), .P2_PAD_OE(p2_oe));
	ppc_pins i_ppc_pins (.pad_out({p2_out, out}), .pad_oe({p2_oe, oe}),
		.pad_pu({1'b1, pu}), .ext_low(ext), .pin_in(pin));
	// One register access; read data is taken one cycle after the request, at the next falling edge.
	task automatic acc(input logic w, b, input logic [2:0] i, input logic [7:0] a, v);
		@(negedge REF_CLK) req = '{w, ~w, b, i, a, v};
		@(negedge REF_CLK) d = rd;
		req = '0;
	endtask : acc
	function automatic logic [7:0] f_oe(logic [7:0] i, o, t, l);
		return i & (o & ~t | ~l);
	endfunction : f_oe
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize
	// Hang guard, far beyond the expected few microseconds.
	initial begin
		#20us fail_count++;
		summarize();
	end
	// Reset values and an unmapped place, then random configurations.
	initial begin
		repeat (4) @(negedge REF_CLK);
		RSTN = 1;
		foreach (ta[k]) begin
			acc(0, 0, 0, ta[k], 0);
			`CHK("reset read", te[k], d)
		end
		$display("reset test done");
		for (int n = 0; n < 24; n++) begin
			{m_in, m_out, sk, lvl} = $random(seed);
			{lat, drv, x} = 5'($random(seed));
			tw = n ? 8'($random(seed) & $random(seed)) : 8'hff;
			ext = 9'($random(seed) & $random(seed) & $random(seed));
			acc(1, 0, 0, 8'hf2, m_in);
			acc(1, 0, 0, 8'ha5, m_out);
			acc(1, 0, 0, 8'hd5, sk);
			acc(1, 0, 0, 8'ha6, {7'h7f, drv});
			acc(1, 0, 0, 8'ha0, {7'h55, ~lat});
			acc(1, 1, x, 8'ha0, {7'h0, lat});
			el = x != 0 ? ~lat : lat;
			acc(0, 0, 0, 8'hf2, 0);
			`CHK("analog select", m_in, d)
			acc(0, 0, 0, 8'ha5, 0);
			`CHK("drive select", m_out, d)
			acc(0, 0, 0, 8'hd5, 0);
			`CHK("bypass", {1'b0, sk[6:0]}, d)
			acc(0, 0, 0, 8'ha6, 0);
			`CHK("p2 drive", {7'h0, drv}, d)
			acc(0, 1, x, 8'ha0, 0);
			`CHK("bit test", x != 0 ? 8'h00 : {7'h0, el & ~ext[8]}, d)
			acc(0, 0, 0, 8'ha0, 0);
			`CHK("p2 pin", {7'h0, el & ~ext[8]}, d)
			e = f_oe(m_in, m_out, tw, lvl);
			`CHK("pull-up", m_in, pu)
			`CHK("receiver", m_in, rx)
			`CHK("drive enable", e, oe)
			`CHK("pin level", m_in & ~ext[7:0] & (~e | lvl), pl)
			`CHK("skip", sk[6:0], skip)
			`CHK("p2 enable", drv | ~el, p2_oe)
			`CHK("pad out", lvl, out)
			`CHK("p2 out", el, p2_out)
		end
		$display("random test done");
		summarize();
	end
endmodule : testbench
bind ppc_top ppc_asserts #(.P1_PINS(P1_PINS)) i_ppc_asserts (.REF_CLK, .RSTN, .SFR_REQ,
	.SFR_RDATA, .P1_TWO_WIRE, .P1_PAD_OUT, .P1_PAD_OE, .P1_PAD_PULLUP_EN, .P1_PAD_RX_EN,
	.P1_PIN_LEVEL, .P2_PIN_IN);
